// ### serial_port_defs.vh
// Constants for the serial port control block: register offsets, field positions, resets.
// Assumes a plain register port with byte offsets and an oscillator-rate clock.
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH
`define ADDR_RX_CTRL 8'h18
`define ADDR_TX_CTRL 8'h98
`define ADDR_BAUD 8'h99
`define ADDR_TX_DATA 8'h19
`define ADDR_RX_DATA 8'h1A
`define ADDR_PORTB_DIR 8'h86
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_MASK 8'h8C
`define TX_CTRL_RESET 8'h02
`define BAUD_RESET 8'h00
`define DIR_RESET 8'hFF
`define B_CLOCK_ORIGIN_SELECT 7
`define B_TX9 6
`define B_TRANSMIT_ENABLE_BIT 5
`define B_SYNC 4
`define B_HIGH_SPEED_BAUD_SELECT 2
`define B_TRANSMIT_NINTH_BIT 0
`define B_SERIAL_PORT_ENABLE 7
`define B_RX9 6
`define B_SINGLE_RECEIVE_ENABLE 5
`define B_CONTINUOUS_RECEIVE_ENABLE 4
`define B_ADDRESS_DETECT_ENABLE 3
`define B_TXDIR 2
`define B_RXDIR 1
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_ERR 2
`define OS_LOW 6'h3F
`define OS_HIGH 6'h0F
`define OS_SYNC 6'h03
`define SAMPLE_A 6'h07
`define SAMPLE_B 6'h08
`define SAMPLE_C 6'h09
`define SAMPLE_A_HI 6'h06
`define SAMPLE_B_HI 6'h07
`define SAMPLE_C_HI 6'h08
`endif

// ### majority_vote.v
// Three-sample majority detector for the receive data line.
// Assumes sample strobes come from the owning receiver, on the system clock.
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module majority_vote (
  input wire mclk,
  input wire rst_n,
  input wire sample,
  input wire clear,
  input wire din,
  output wire level
);
  reg [2:0] shift_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 3'h7;
    end else if (clear) begin
      shift_q <= 3'h7;
    end else if (sample) begin
      shift_q <= {shift_q[1:0], din};
    end
  end
  assign level = (shift_q[0] & shift_q[1]) | (shift_q[1] & shift_q[2]) |
                 (shift_q[0] & shift_q[2]);
endmodule // majority_vote

// ### serial_port.v
// Serial port control, status, baud generator, transmitter and receiver.
// Assumes a one-cycle register port with read data the cycle after the read strobe.
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_port (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output wire irq,
  input wire tx_clk_in,
  output wire tx_clk_out,
  output wire tx_clk_oe_n,
  input wire rx_data_in,
  output wire rx_data_out,
  output wire rx_data_oe_n
);
  localparam S_IDLE = 4'h1;
  localparam S_START = 4'h2;
  localparam S_DATA = 4'h4;
  localparam S_STOP = 4'h8;

  reg [1:0] rst_sync_q;
  wire rst_i_n = rst_sync_q[1];
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  reg [7:0] tx_ctrl_q, rx_ctrl_q, baud_q, dir_q, tx_buf_q, rx_buf_q, mask_q;
  reg [2:0] stat_q;
  reg tx_buf_full_q, rx_full_q, receive_ninth_bit_q, framing_error_flag_q, overrun_error_flag_q;
  wire sync_mode = tx_ctrl_q[`B_SYNC];
  wire master = tx_ctrl_q[`B_CLOCK_ORIGIN_SELECT];
  wire transmit_enable_bit = tx_ctrl_q[`B_TRANSMIT_ENABLE_BIT];
  wire serial_port_enable = rx_ctrl_q[`B_SERIAL_PORT_ENABLE];
  wire continuous_receive_enable = rx_ctrl_q[`B_CONTINUOUS_RECEIVE_ENABLE];
  wire pins_on = serial_port_enable & dir_q[`B_TXDIR] & dir_q[`B_RXDIR];
  wire wr_baud = wr && addr == `ADDR_BAUD;
  wire rd_rx = rd && addr == `ADDR_RX_DATA;

  // Baud timer: tick every divisor+1 clocks; oversample count per bit by mode.
  reg [7:0] brg_q;
  wire brg_tick = (brg_q == 8'h00);
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) brg_q <= `BAUD_RESET;
    else if (wr_baud) brg_q <= wdata;
    else if (brg_tick) brg_q <= baud_q;
    else brg_q <= brg_q - 8'h01;
  end
  wire [5:0] os_last = sync_mode ? `OS_SYNC :
                       (tx_ctrl_q[`B_HIGH_SPEED_BAUD_SELECT] ? `OS_HIGH : `OS_LOW);

  // External clock edges for slave mode (inputs are synchronous).
  reg ck_in_q;
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) ck_in_q <= 1'b1;
    else ck_in_q <= tx_clk_in;
  end
  wire ext_rise = tx_clk_in & ~ck_in_q;
  wire ext_fall = ~tx_clk_in & ck_in_q;

  // Transmitter.
  reg [3:0] ts_q;
  reg [5:0] tos_q;
  reg [8:0] tsr_q;
  reg [3:0] tcnt_q;
  reg tx_line_q, sck_q;
  wire nine_tx = tx_ctrl_q[`B_TX9];
  wire [3:0] nbits = nine_tx ? 4'h9 : 4'h8;
  wire rx_bits9 = rx_ctrl_q[`B_RX9];
  wire tos_end = brg_tick && tos_q == os_last;
  // Sync master: half-bit edges every two baud ticks.
  wire m_half = brg_tick && tos_q[0];
  wire shift_ev = sync_mode ? (master ? (m_half & sck_q) : ext_fall) : tos_end;
  wire tsr_empty = (ts_q == S_IDLE);
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ts_q <= S_IDLE;
      tos_q <= 6'h00;
      tsr_q <= 9'h1FF;
      tcnt_q <= 4'h0;
      tx_line_q <= 1'b1;
      sck_q <= 1'b1;
    end else if (!transmit_enable_bit || !pins_on) begin
      ts_q <= S_IDLE;
      tos_q <= 6'h00;
      tx_line_q <= 1'b1;
      sck_q <= 1'b1;
    end else begin
      if (brg_tick) tos_q <= (tos_q == os_last) ? 6'h00 : tos_q + 6'h01;
      if (sync_mode && master && m_half && !tsr_empty) sck_q <= ~sck_q;
      case (ts_q)
        S_IDLE: begin
          sck_q <= 1'b1;
          if (tx_buf_full_q && (sync_mode || tos_end)) begin
            tsr_q <= {tx_ctrl_q[`B_TRANSMIT_NINTH_BIT], tx_buf_q};
            tcnt_q <= 4'h0;
            ts_q <= sync_mode ? S_DATA : S_START;
            tx_line_q <= sync_mode ? tx_buf_q[0] : 1'b0;
          end
        end
        S_START: if (shift_ev) begin
          ts_q <= S_DATA;
          tx_line_q <= tsr_q[0];
        end
        S_DATA: if (shift_ev) begin
          tsr_q <= {1'b1, tsr_q[8:1]};
          tcnt_q <= tcnt_q + 4'h1;
          if (tcnt_q == nbits - 4'h1) begin
            ts_q <= sync_mode ? S_IDLE : S_STOP;
            tx_line_q <= 1'b1;
          end else begin
            tx_line_q <= tsr_q[1];
          end
        end
        S_STOP: if (shift_ev) ts_q <= S_IDLE;
        default: ts_q <= S_IDLE;
      endcase
    end
  end
  wire tx_load = (ts_q == S_IDLE) && transmit_enable_bit && pins_on && tx_buf_full_q &&
                 (sync_mode || tos_end);

  // Receiver: async with 3-sample majority; sync samples on clock edges.
  reg [3:0] rs_q;
  reg [5:0] ros_q;
  reg [8:0] rsr_q;
  reg [3:0] rcnt_q;
  reg rdone_q, rferr_q;
  wire maj;
  wire rx_en = pins_on && (continuous_receive_enable || (sync_mode && rx_ctrl_q[`B_SINGLE_RECEIVE_ENABLE]));
  wire hs = tx_ctrl_q[`B_HIGH_SPEED_BAUD_SELECT];
  wire [5:0] sa = hs ? `SAMPLE_A_HI : `SAMPLE_A;
  wire [5:0] sb = hs ? `SAMPLE_B_HI : `SAMPLE_B;
  wire [5:0] sc = hs ? `SAMPLE_C_HI : `SAMPLE_C;
  wire samp = brg_tick && (ros_q == sa || ros_q == sb || ros_q == sc);
  wire [3:0] rbits = rx_bits9 ? 4'h9 : 4'h8;
  wire r_end = brg_tick && ros_q == os_last;
  wire sync_samp = master ? (m_half & ~sck_q) : ext_rise;
  majority_vote u_vote (
    .mclk(mclk),
    .rst_n(rst_i_n),
    .sample(samp),
    .clear(rs_q == S_IDLE),
    .din(rx_data_in),
    .level(maj)
  );
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rs_q <= S_IDLE;
      ros_q <= 6'h00;
      rsr_q <= 9'h000;
      rcnt_q <= 4'h0;
      rdone_q <= 1'b0;
      rferr_q <= 1'b0;
    end else begin
      rdone_q <= 1'b0;
      if (brg_tick) ros_q <= (ros_q == os_last) ? 6'h00 : ros_q + 6'h01;
      if (!rx_en) begin
        rs_q <= S_IDLE;
      end else if (sync_mode) begin
        if (sync_samp) begin
          rsr_q <= {rx_data_in, rsr_q[8:1]};
          rcnt_q <= (rcnt_q == rbits - 4'h1) ? 4'h0 : rcnt_q + 4'h1;
          rdone_q <= (rcnt_q == rbits - 4'h1);
          rferr_q <= 1'b0;
        end
      end else begin
        case (rs_q)
          S_IDLE: if (!rx_data_in) begin
            rs_q <= S_START;
            ros_q <= 6'h00;
            rcnt_q <= 4'h0;
          end
          S_START: if (r_end) rs_q <= maj ? S_IDLE : S_DATA;
          S_DATA: if (r_end) begin
            rsr_q <= {maj, rsr_q[8:1]};
            rcnt_q <= rcnt_q + 4'h1;
            if (rcnt_q == rbits - 4'h1) rs_q <= S_STOP;
          end
          S_STOP: if (r_end) begin
            rs_q <= S_IDLE;
            rdone_q <= 1'b1;
            rferr_q <= ~maj;
          end
          default: rs_q <= S_IDLE;
        endcase
      end
    end
  end
  // Right-align eight-bit characters, which shifted in one place short.
  wire [8:0] rword = rx_bits9 ? rsr_q : {1'b0, rsr_q[8:1]};
  wire addr_ok = !(rx_bits9 && rx_ctrl_q[`B_ADDRESS_DETECT_ENABLE] && !sync_mode) || rword[8];
  wire rx_take = rdone_q && addr_ok;

  // Registers, status and interrupt flags.
  wire [2:0] events = {rx_take & rx_full_q, tx_load, rx_take};
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      tx_ctrl_q <= `TX_CTRL_RESET;
      rx_ctrl_q <= 8'h00;
      baud_q <= `BAUD_RESET;
      dir_q <= `DIR_RESET;
      tx_buf_q <= 8'h00;
      tx_buf_full_q <= 1'b0;
      rx_buf_q <= 8'h00;
      rx_full_q <= 1'b0;
      receive_ninth_bit_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      mask_q <= 8'h00;
      stat_q <= 3'h0;
      rdata <= 8'h00;
    end else begin
      if (wr && addr == `ADDR_TX_CTRL) tx_ctrl_q <= wdata;
      if (wr && addr == `ADDR_RX_CTRL) rx_ctrl_q <= {wdata[7:3], 3'h0};
      if (wr_baud) baud_q <= wdata;
      if (wr && addr == `ADDR_PORTB_DIR) dir_q <= wdata;
      if (wr && addr == `ADDR_IRQ_MASK) mask_q <= wdata;
      if (wr && addr == `ADDR_TX_DATA) begin
        tx_buf_q <= wdata;
        tx_buf_full_q <= 1'b1;
      end else if (tx_load) begin
        tx_buf_full_q <= 1'b0;
      end
      if (rx_take && !rx_full_q) begin
        rx_buf_q <= rword[7:0];
        receive_ninth_bit_q <= rword[8];
        framing_error_flag_q <= rferr_q;
        rx_full_q <= 1'b1;
      end else if (rd_rx) begin
        rx_full_q <= 1'b0;
      end
      if (rx_take && rx_full_q) overrun_error_flag_q <= 1'b1;
      else if (!continuous_receive_enable) overrun_error_flag_q <= 1'b0;
      if (rx_ctrl_q[`B_SINGLE_RECEIVE_ENABLE] && sync_mode && rx_take && !continuous_receive_enable)
        rx_ctrl_q[`B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
      if (rd && addr == `ADDR_IRQ_STAT) stat_q <= events;
      else stat_q <= stat_q | events;
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `ADDR_TX_CTRL: rdata <= {tx_ctrl_q[7:4], 1'b0, tx_ctrl_q[2], tsr_empty,
                                   tx_ctrl_q[0]};
          `ADDR_RX_CTRL: rdata <= {rx_ctrl_q[7:3], framing_error_flag_q, overrun_error_flag_q, receive_ninth_bit_q};
          `ADDR_BAUD: rdata <= baud_q;
          `ADDR_RX_DATA: rdata <= rx_buf_q;
          `ADDR_PORTB_DIR: rdata <= dir_q;
          `ADDR_IRQ_STAT: rdata <= {5'h00, stat_q};
          `ADDR_IRQ_MASK: rdata <= mask_q;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
  assign irq = |(stat_q & mask_q[2:0]);

  // Pins: async drives TX on pin B2; sync master drives clock, data on B1 half duplex.
  wire tx_active = pins_on && transmit_enable_bit;
  assign tx_clk_out = (sync_mode && master) ? sck_q : tx_line_q;
  assign tx_clk_oe_n = ~(pins_on && (sync_mode ? master : transmit_enable_bit));
  assign rx_data_out = tx_line_q;
  assign rx_data_oe_n = ~(tx_active && sync_mode && !rx_en);
endmodule // serial_port

// ### serial_port_checker.sv
// Checker for the serial port: register answers, interrupt masking and transmit timing.
// Assumes it is bound to serial_port and sees only that module's ports.
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_port_checker (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire irq,
  input wire tx_clk_out,
  input wire tx_clk_oe_n,
  input wire rx_data_oe_n
);
  reg [7:0] txctl_q;
  reg [7:0] baud_q;
  reg [7:0] mask_q;
  reg serial_port_enable_q;
  reg last_q;
  reg [1:0] dir_q;
  reg [15:0] run_q;
  wire port_on = serial_port_enable_q & dir_q[1] & dir_q[0];
  wire [15:0] bit_len = (txctl_q[`B_HIGH_SPEED_BAUD_SELECT] ? 16'h0010 : 16'h0040) * ({8'h00, baud_q} + 16'h0001);
  wire mapped = addr inside {`ADDR_RX_CTRL, `ADDR_TX_CTRL, `ADDR_BAUD, `ADDR_TX_DATA,
    `ADDR_RX_DATA, `ADDR_PORTB_DIR, `ADDR_IRQ_STAT, `ADDR_IRQ_MASK};
  // Shadow copies of the registers, and the length of the current level on the line.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txctl_q <= `TX_CTRL_RESET;
      baud_q <= `BAUD_RESET;
      mask_q <= 8'h00;
      serial_port_enable_q <= 1'b0;
      dir_q <= 2'h3;
      last_q <= 1'b1;
      run_q <= 16'h0000;
    end else begin
      if (wr && addr == `ADDR_TX_CTRL) txctl_q <= wdata;
      if (wr && addr == `ADDR_BAUD) baud_q <= wdata;
      if (wr && addr == `ADDR_IRQ_MASK) mask_q <= wdata;
      if (wr && addr == `ADDR_RX_CTRL) serial_port_enable_q <= wdata[`B_SERIAL_PORT_ENABLE];
      if (wr && addr == `ADDR_PORTB_DIR) dir_q <= {wdata[`B_TXDIR], wdata[`B_RXDIR]};
      last_q <= tx_clk_out;
      run_q <= (tx_clk_out != last_q) ? 16'h0001 : run_q + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (rd && !mapped |=> rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
  baud_readback_a: assert property (rd && addr == `ADDR_BAUD |=> rdata == baud_q)
    else $error("baud divisor read back wrong");
  tx_ctrl_read_a: assert property (rd && addr == `ADDR_TX_CTRL |=>
    rdata[7:2] == {txctl_q[7:4], 1'b0, txctl_q[2]}) else $error("transmit control read wrong");
  pins_released_a: assert property (!port_on && !$past(port_on) |-> tx_clk_oe_n && rx_data_oe_n)
    else $error("pin driven while serial port is off");
  tx_abort_a: assert property ($fell(txctl_q[`B_TRANSMIT_ENABLE_BIT]) && !txctl_q[`B_SYNC] |-> ##2 tx_clk_oe_n)
    else $error("transmit pin still driven after transmit disable");
  bit_length_a: assert property (tx_clk_out && !last_q && !tx_clk_oe_n && !txctl_q[`B_SYNC]
    |-> run_q % bit_len == 16'h0000)
    else $error("low run on transmit line not a whole number of bits");
  irq_masked_a: assert property (mask_q[2:0] == 3'h0 |-> !irq)
    else $error("interrupt high while all sources masked");
  cover property (tx_clk_out && !last_q && !tx_clk_oe_n);
  cover property ($rose(irq));
  cover property (rd && !mapped);
endmodule // serial_port_checker
bind serial_port serial_port_checker chk (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .tx_clk_out(tx_clk_out),
  .tx_clk_oe_n(tx_clk_oe_n), .rx_data_oe_n(rx_data_oe_n));

// ### serial_terminal.sv
// Remote asynchronous terminal: sends frames to the port and captures the frames it sends.
// Assumes the bench gives the bit length in clock cycles and a pulled-up transmit line.
`timescale 1ns/10ps
module serial_terminal (
  input wire mclk,
  input wire [15:0] bit_len,
  input wire line_in,
  output logic line_out,
  output logic [7:0] got,
  output logic [7:0] got_count
);
  logic [7:0] shift;
  initial begin
    line_out = 1'b1;
    got = 8'h00;
    got_count = 8'h00;
  end
  task send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= frame[i];
      repeat (bit_len) @(posedge mclk);
    end
  endtask
  // Samples each data bit in its middle, starting from the falling edge of the start bit.
  always begin
    @(negedge line_in);
    repeat (bit_len / 2) @(posedge mclk);
    for (int j = 0; j < 8; j++) begin
      repeat (bit_len) @(posedge mclk);
      shift[j] = line_in;
    end
    repeat (bit_len) @(posedge mclk);
    got <= shift;
    got_count <= got_count + 8'h01;
  end
endmodule // serial_terminal

// ### serial_port_tb.sv
// Self-checking bench for the serial port with a remote terminal on its pins.
// Assumes the checker is bound to the design and a 100 MHz clock.
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_port_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] bit_len = 16'h0010;
  wire [7:0] rdata;
  wire [7:0] got;
  wire [7:0] got_count;
  wire irq, tx_clk_out, tx_clk_oe_n, rx_data_out, rx_data_oe_n, term_line;
  int mismatches = 0;
  int check_count = 0;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows [0:6];
  wire tx_line = tx_clk_oe_n ? 1'b1 : tx_clk_out;
  wire rx_line = rx_data_oe_n ? term_line : rx_data_out;
  always #5 mclk = ~mclk;
  serial_port uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .tx_clk_in(tx_line), .tx_clk_out(tx_clk_out),
    .tx_clk_oe_n(tx_clk_oe_n), .rx_data_in(rx_line), .rx_data_out(rx_data_out),
    .rx_data_oe_n(rx_data_oe_n));
  serial_terminal term (.mclk(mclk), .bit_len(bit_len), .line_in(tx_line),
    .line_out(term_line), .got(got), .got_count(got_count));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task wait_bytes(input logic [7:0] n);
    repeat (3000) if (got_count < n) @(posedge mclk);
    check(got_count, n);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test;
  end
  initial begin
    rows[0] = '{`ADDR_BAUD, 8'h5A, 8'h5A};
    rows[1] = '{`ADDR_BAUD, 8'h00, 8'h00};
    rows[2] = '{`ADDR_TX_CTRL, 8'h0B, 8'h03};
    rows[3] = '{`ADDR_IRQ_MASK, 8'h05, 8'h05};
    rows[4] = '{`ADDR_IRQ_MASK, 8'h00, 8'h00};
    rows[5] = '{8'h40, 8'hFF, 8'h00};
    rows[6] = '{`ADDR_RX_CTRL, 8'h00, 8'h00};
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_reg(`ADDR_TX_CTRL, `TX_CTRL_RESET);
    rd_reg(`ADDR_BAUD, `BAUD_RESET);
    rd_reg(`ADDR_RX_CTRL, 8'h00);
    rd_reg(`ADDR_PORTB_DIR, `DIR_RESET);
    rd_reg(`ADDR_IRQ_MASK, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rows[i].e);
    end
    wr_reg(`ADDR_TX_CTRL, 8'h24);
    repeat (2) @(posedge mclk);
    #1 check({7'h00, tx_clk_oe_n}, 8'h01);
    wr_reg(`ADDR_RX_CTRL, 8'h80);
    wr_reg(`ADDR_TX_DATA, 8'hA5);
    wait_bytes(8'h01);
    check(got, 8'hA5);
    bit_len <= 16'h0080;
    wr_reg(`ADDR_BAUD, 8'h01);
    wr_reg(`ADDR_TX_CTRL, 8'h20);
    wr_reg(`ADDR_TX_DATA, 8'h3C);
    wait_bytes(8'h02);
    check(got, 8'h3C);
    bit_len <= 16'h0010;
    wr_reg(`ADDR_BAUD, 8'h00);
    wr_reg(`ADDR_TX_CTRL, 8'h24);
    rd_reg(`ADDR_IRQ_STAT, 8'h02);
    wr_reg(`ADDR_IRQ_MASK, 8'h01);
    wr_reg(`ADDR_RX_CTRL, 8'h90);
    term.send(8'hC3);
    // The receiver ends its stop bit a couple of cycles after the terminal lets go.
    repeat (6) @(posedge mclk);
    #1 check({7'h00, irq}, 8'h01);
    rd_reg(`ADDR_RX_DATA, 8'hC3);
    rd_reg(`ADDR_IRQ_STAT, 8'h01);
    check({7'h00, irq}, 8'h00);
    term.send(8'hD1);
    term.send(8'hE2);
    repeat (6) @(posedge mclk);
    rd_reg(`ADDR_RX_CTRL, 8'h92);
    rd_reg(`ADDR_RX_DATA, 8'hD1);
    wr_reg(`ADDR_RX_CTRL, 8'h80);
    rd_reg(`ADDR_RX_CTRL, 8'h80);
    // Disable the transmitter in the middle of a frame.
    wr_reg(`ADDR_TX_DATA, 8'h55);
    repeat (200) if (tx_line) @(posedge mclk);
    repeat (20) @(posedge mclk);
    wr_reg(`ADDR_TX_CTRL, 8'h04);
    repeat (2) @(posedge mclk);
    #1 check({7'h00, tx_clk_oe_n}, 8'h01);
    finish_test;
  end
endmodule // serial_port_tb
